// ===== rtl/sfct_table.sv
// capability table lookup and write/erase prefix sequencer
`timescale 1ns/1ps
module sfct_table (
  input wire logic sys_clk,
  input wire logic resetn,
  input wire sfct_pkg::sfct_bus_req_t bus_req,
  output sfct_pkg::sfct_word_t bus_rdata,
  output sfct_pkg::sfct_cmd_t cmd,
  output logic busy
);
  import sfct_pkg::*;

  typedef struct packed {
    sfct_fsm_t fsm;
    logic [6:0] n;
    sfct_word_t upper_map;
    logic [23:0] part_id;
    logic [24:0] boundary;
    logic [24:0] faddr;
    logic erase;
    sfct_word_t cap;
    logic match;
    logic nomatch;
    logic refused;
    logic [6:0] match_idx;
    sfct_region_t region;
    sfct_cmd_t cmd;
    sfct_word_t rdata;
    logic busy;
  } sfct_state_t;

  ////////////////////////////////////////////////////////////////////////
  // pick lower or upper fields of a capability word
  function automatic sfct_region_t pick_region(input sfct_word_t cw,
                                               input logic upper);
    sfct_region_t r;
    r.upper = upper;
    if (upper) begin
      r.erase_op = cw[CAP_UP_OP_LSB +: 8];
      r.unl_wren = cw[CAP_UP_WREN];
      r.unl_ewsr = cw[CAP_UP_EWSR];
      r.gran64 = cw[CAP_UP_GRAN];
      r.sector = cw[CAP_UP_SECT_LSB +: 2];
    end else begin
      r.erase_op = cw[CAP_LOW_OP_LSB +: 8];
      r.unl_wren = cw[CAP_LOW_WREN];
      r.unl_ewsr = cw[CAP_LOW_EWSR];
      r.gran64 = cw[CAP_LOW_GRAN];
      r.sector = cw[CAP_LOW_SECT_LSB +: 2];
    end
    return r;
  endfunction

  function automatic logic [16:0] sector_bytes(input logic [1:0] code);
    case (code)
      2'b00: sector_bytes = 17'h00100;
      2'b01: sector_bytes = 17'h01000;
      2'b10: sector_bytes = 17'h02000;
      default: sector_bytes = 17'h10000;
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // reset release
  logic rst_meta_n_r;
  logic rst_n_r;

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      rst_meta_n_r <= 1'b0;
      rst_n_r <= 1'b0;
    end else begin
      rst_meta_n_r <= 1'b1;
      rst_n_r <= rst_meta_n_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // descriptor image, loaded by software; no reset on purpose
  sfct_word_t desc_mem [0:DESC_WORDS-1];
  logic desc_hit;

  assign desc_hit = (bus_req.addr[12] == 1'b0) &&
                    (bus_req.addr != OFS_UPPER_MAP);

  always_ff @(posedge sys_clk) begin
    if (bus_req.wr && desc_hit) begin
      desc_mem[bus_req.addr[11:2]] <= bus_req.wdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // table walk addressing
  sfct_state_t s_r;
  sfct_state_t s_nxt;
  logic [6:0] entries;
  logic [9:0] start_w;
  logic [9:0] ident_w;
  logic [9:0] cap_w;
  sfct_word_t ident_word;
  sfct_region_t cur_region;
  logic go_upper;

  // one-based dword count, entry = two dwords; odd dword is ignored
  assign entries = s_r.upper_map[UM_LEN_LSB + 1 +: 7];
  // base at byte bits 11:4 means word index bits 9:2
  assign start_w = {s_r.upper_map[UM_BASE_LSB +: 8], 2'b00};
  assign ident_w = 10'(start_w + {2'b00, s_r.n, 1'b0});
  assign cap_w = 10'(ident_w + 10'h001);
  assign ident_word = desc_mem[ident_w];
  // equal to the boundary counts as upper space
  assign go_upper = (s_r.faddr >= s_r.boundary);
  assign cur_region = pick_region(s_r.cap, go_upper);

  ////////////////////////////////////////////////////////////////////////
  always_comb begin
    s_nxt = s_r;
    s_nxt.cmd = '0;

    // register writes
    if (bus_req.wr) begin
      case (bus_req.addr)
        OFS_UPPER_MAP: s_nxt.upper_map = bus_req.wdata;
        OFS_PART_ID: s_nxt.part_id = bus_req.wdata[23:0];
        OFS_BOUNDARY: s_nxt.boundary = bus_req.wdata[24:0];
        OFS_FLASH_ADDR: s_nxt.faddr = bus_req.wdata[24:0];
        default: begin
        end
      endcase
    end

    // register reads, answer in the next cycle only
    s_nxt.rdata = '0;
    if (bus_req.rd) begin
      if (desc_hit) begin
        s_nxt.rdata = desc_mem[bus_req.addr[11:2]];
      end else begin
        case (bus_req.addr)
          OFS_UPPER_MAP: s_nxt.rdata = s_r.upper_map;
          OFS_PART_ID: s_nxt.rdata = {8'h00, s_r.part_id};
          OFS_BOUNDARY: s_nxt.rdata = {7'h00, s_r.boundary};
          OFS_FLASH_ADDR: s_nxt.rdata = {7'h00, s_r.faddr};
          OFS_STATUS: begin
            s_nxt.rdata[ST_BUSY] = s_r.busy;
            s_nxt.rdata[ST_MATCH] = s_r.match;
            s_nxt.rdata[ST_NOMATCH] = s_r.nomatch;
            s_nxt.rdata[ST_REFUSED] = s_r.refused;
            s_nxt.rdata[ST_IDX_LSB +: 7] = s_r.match_idx;
          end
          OFS_ACTIVE_CAP: s_nxt.rdata = s_r.cap;
          OFS_DECODE: s_nxt.rdata = {18'h00000, cur_region};
          OFS_SIZES: begin
            // granularity in bytes at 30:24, sector bytes at 16:0
            s_nxt.rdata[16:0] = sector_bytes(cur_region.sector);
            s_nxt.rdata[30:24] = cur_region.gran64 ? 7'h40 : 7'h01;
          end
          default: s_nxt.rdata = '0;
        endcase
      end
    end

    case (s_r.fsm)
      SFCT_IDLE: begin
        s_nxt.busy = 1'b0;
        if (bus_req.wr && bus_req.addr == OFS_CTRL) begin
          if (bus_req.wdata[CTRL_SCAN]) begin
            s_nxt.fsm = SFCT_SCAN;
            s_nxt.n = '0;
            s_nxt.match = 1'b0;
            s_nxt.nomatch = 1'b0;
            s_nxt.busy = 1'b1;
          end else if (bus_req.wdata[CTRL_GO]) begin
            // no table entry selected: nothing safe to send
            if (!s_r.match) begin
              s_nxt.refused = 1'b1;
            end else begin
              s_nxt.refused = 1'b0;
              s_nxt.erase = bus_req.wdata[CTRL_ERASE];
              s_nxt.region = cur_region;
              s_nxt.busy = 1'b1;
              if (cur_region.unl_wren || cur_region.unl_ewsr) begin
                s_nxt.fsm = SFCT_UNLOCK;
              end else begin
                s_nxt.fsm = SFCT_MAIN;
              end
            end
          end
        end
      end
      SFCT_SCAN: begin
        if (s_r.n >= entries) begin
          s_nxt.nomatch = 1'b1;
          s_nxt.fsm = SFCT_IDLE;
          s_nxt.busy = 1'b0;
        end else if (ident_word[23:0] == s_r.part_id) begin
          s_nxt.cap = desc_mem[cap_w];
          s_nxt.match = 1'b1;
          s_nxt.match_idx = s_r.n;
          s_nxt.fsm = SFCT_IDLE;
          s_nxt.busy = 1'b0;
        end else begin
          s_nxt.n = 7'(s_r.n + 7'h01);
        end
      end
      SFCT_UNLOCK: begin
        // 06h wins if both bits are wrongly set
        s_nxt.cmd.valid = 1'b1;
        s_nxt.cmd.data = s_r.region.unl_wren ? OP_WREN : OP_EWSR;
        s_nxt.fsm = SFCT_WRSR;
      end
      SFCT_WRSR: begin
        s_nxt.cmd.valid = 1'b1;
        s_nxt.cmd.data = OP_WRSR;
        s_nxt.fsm = SFCT_SRDATA;
      end
      SFCT_SRDATA: begin
        s_nxt.cmd.valid = 1'b1;
        s_nxt.cmd.data = SR_UNLOCK_VAL;
        s_nxt.fsm = SFCT_MAIN;
      end
      SFCT_MAIN: begin
        s_nxt.cmd.valid = 1'b1;
        s_nxt.cmd.data = s_r.erase ? s_r.region.erase_op : OP_PROGRAM;
        s_nxt.fsm = SFCT_IDLE;
        s_nxt.busy = 1'b0;
      end
      default: begin
        s_nxt.fsm = SFCT_IDLE;
        s_nxt.busy = 1'b0;
      end
    endcase
  end

  always_ff @(posedge sys_clk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      s_r <= '0;
      s_r.upper_map <= UPPER_MAP_RST;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign bus_rdata = s_r.rdata;
  assign cmd = s_r.cmd;
  assign busy = s_r.busy;

endmodule

// ===== rtl/sfct_pkg.sv
// constants and types for the flash part capability table block
// Notes on behaviour
// - length in bits 15:8 of upper map, one-based dwords, two per entry
// - table start: base field at address bits 11:4, other bits zero
// - entry n at start plus n*8: ident word then capability word at +4
// - ident word holds id-read bytes one, two, three in 7:0, 15:8, 23:16
// - lower fields below partition boundary, upper fields at or above it
// - bit 20: send 06h then write 00h to status before lower write/erase
// - bit 19: send 50h then write 00h to status before lower write/erase
// - bit 18 lower write granularity: 0 one byte, 1 sixty-four bytes
// - bits 17:16 lower sector: 256 bytes, 4 KB, 8 KB, 64 KB
// - bit 4: send 06h then write 00h to status before upper write/erase
// - bit 3: send 50h then write 00h to status before upper write/erase
// - bit 2 upper write granularity: 0 one byte, 1 sixty-four bytes
package sfct_pkg;

  typedef logic [12:0] sfct_addr_t;
  typedef logic [31:0] sfct_word_t;

  // descriptor image occupies 0x000..0xffc except 0xefc (upper map); other block registers above it
  localparam sfct_addr_t OFS_UPPER_MAP = 13'h0efc;
  localparam sfct_addr_t OFS_CTRL = 13'h1000;
  localparam sfct_addr_t OFS_PART_ID = 13'h1004;
  localparam sfct_addr_t OFS_BOUNDARY = 13'h1008;
  localparam sfct_addr_t OFS_FLASH_ADDR = 13'h100c;
  localparam sfct_addr_t OFS_STATUS = 13'h1010;
  localparam sfct_addr_t OFS_ACTIVE_CAP = 13'h1014;
  localparam sfct_addr_t OFS_DECODE = 13'h1018;
  localparam sfct_addr_t OFS_SIZES = 13'h101c;
  localparam int DESC_WORDS = 1024;

  localparam sfct_word_t UPPER_MAP_RST = 32'h0000ffff;
  localparam int UM_LEN_LSB = 8;
  localparam int UM_BASE_LSB = 0;

  // capability word layout
  localparam int CAP_LOW_OP_LSB = 24;
  localparam int CAP_LOW_WREN = 20;
  localparam int CAP_LOW_EWSR = 19;
  localparam int CAP_LOW_GRAN = 18;
  localparam int CAP_LOW_SECT_LSB = 16;
  localparam int CAP_UP_OP_LSB = 8;
  localparam int CAP_UP_WREN = 4;
  localparam int CAP_UP_EWSR = 3;
  localparam int CAP_UP_GRAN = 2;
  localparam int CAP_UP_SECT_LSB = 0;

  // control and status bits
  localparam int CTRL_SCAN = 0;
  localparam int CTRL_GO = 1;
  localparam int CTRL_ERASE = 2;
  localparam int ST_BUSY = 0;
  localparam int ST_MATCH = 1;
  localparam int ST_NOMATCH = 2;
  localparam int ST_REFUSED = 3;
  localparam int ST_IDX_LSB = 8;

  // serial flash instructions
  localparam logic [7:0] OP_READ_ID = 8'h9f;
  localparam logic [7:0] OP_WREN = 8'h06;
  localparam logic [7:0] OP_EWSR = 8'h50;
  localparam logic [7:0] OP_WRSR = 8'h01;
  localparam logic [7:0] SR_UNLOCK_VAL = 8'h00;
  localparam logic [7:0] OP_PROGRAM = 8'h02;

  typedef enum logic [2:0] {
    SFCT_IDLE = 3'b000,
    SFCT_SCAN = 3'b001,
    SFCT_UNLOCK = 3'b010,
    SFCT_WRSR = 3'b011,
    SFCT_SRDATA = 3'b100,
    SFCT_MAIN = 3'b101
  } sfct_fsm_t;

  typedef struct packed {
    logic rd;
    logic wr;
    sfct_addr_t addr;
    sfct_word_t wdata;
  } sfct_bus_req_t;

  typedef struct packed {
    logic valid;
    logic [7:0] data;
  } sfct_cmd_t;

  typedef struct packed {
    logic upper;
    logic [7:0] erase_op;
    logic unl_wren;
    logic unl_ewsr;
    logic gran64;
    logic [1:0] sector;
  } sfct_region_t;

endpackage

// ===== dv/sfct_props.sv
// assertion checker for the capability table block
`timescale 1ns/1ps
module sfct_props (
  input wire logic sys_clk,
  input wire logic resetn,
  input wire sfct_pkg::sfct_bus_req_t bus_req,
  input wire sfct_pkg::sfct_word_t bus_rdata,
  input wire sfct_pkg::sfct_cmd_t cmd,
  input wire logic busy
);
  import sfct_pkg::*;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!resetn);
  AST_UNL_WREN:
    assert property (cmd.valid && busy && cmd.data == 8'h06 |=>
      cmd.valid && cmd.data == OP_WRSR ##1 cmd.valid && cmd.data == 8'h00
      ##1 cmd.valid && !busy) else $error("06h prefix sequence broken");
  AST_UNL_EWSR:
    assert property (cmd.valid && busy && cmd.data == 8'h50 |=>
      cmd.valid && cmd.data == OP_WRSR ##1 cmd.valid && cmd.data == 8'h00
      ##1 cmd.valid && !busy) else $error("50h prefix sequence broken");
  AST_PREFIX_OP:
    assert property (cmd.valid && busy && !$past(cmd.valid) |->
      cmd.data == 8'h06 || cmd.data == 8'h50)
      else $error("first prefix byte is no unlock opcode");
  AST_CMD_IN_SEQ:
    assert property (cmd.valid |-> $past(busy))
      else $error("command byte outside a sequence");
  AST_MAIN_LAST:
    assert property (cmd.valid && !busy |=> !cmd.valid [*2])
      else $error("byte after the main opcode");
  AST_SCAN_START:
    assert property (bus_req.wr && bus_req.addr == OFS_CTRL && !busy &&
      bus_req.wdata[CTRL_SCAN] |=> busy) else $error("scan not started");
  AST_SCAN_BOUND:
    assert property ($rose(busy) |-> ##[1:140] !busy)
      else $error("busy held too long");
  AST_RDATA_ZERO:
    assert property (!$past(bus_req.rd) |-> bus_rdata == 32'h0)
      else $error("read data outside answer cycle");
  AST_DATA_ZERO:
    assert property (!cmd.valid |-> cmd.data == 8'h00)
      else $error("command byte without valid");
  cover property (cmd.valid && busy && cmd.data == 8'h06);
  cover property (cmd.valid && busy && cmd.data == 8'h50);
  cover property ($fell(busy) && !cmd.valid);
endmodule

// ===== dv/sfct_flash_model.sv
// listening model of the serial flash part
`timescale 1ns/1ps
module sfct_flash_model (
  input wire logic sys_clk,
  input wire sfct_pkg::sfct_cmd_t cmd
);
  import sfct_pkg::*;
  logic [7:0] byte_log[$];
  logic [1:0] st_r = 2'h0;
  int misuse = 0;
  // status write only lands after an unlock prefix, then 00h
  always @(posedge sys_clk) begin
    if (cmd.valid) begin
      byte_log.push_back(cmd.data);
      if (st_r == 2'h1 && cmd.data !== OP_WRSR) misuse++;
      if (st_r == 2'h2 && cmd.data !== 8'h00) misuse++;
      // modelled part: volatile status register, knows 50h
      if (st_r != 2'h0) st_r <= st_r == 2'h2 ? 2'h0 : 2'h2;
      else if (cmd.data == OP_WREN) st_r <= 2'h1;
      else if (cmd.data == OP_EWSR) st_r <= 2'h1;
    end
  end
endmodule

// ===== dv/testbench.sv
// self-checking bench for the capability table block
`timescale 1ns/1ps
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin fails++; \
  $display("[ERR] %0t got %h exp %h", $time, a, b); end end
module testbench;
  import sfct_pkg::*;
  logic sys_clk = 1'b0;
  logic resetn = 1'b0;
  sfct_bus_req_t bus_req = '0;
  sfct_word_t bus_rdata, d, fba, id[5], cap[5];
  sfct_cmd_t cmd;
  logic busy;
  logic [7:0] b, exp_q[$];
  logic [12:0] r;
  int fails = 0;
  int compares = 0;
  int seed = 32'hd567fec8;
  always #2.5 sys_clk = ~sys_clk;
  sfct_table sfct_table_i (.sys_clk(sys_clk), .resetn(resetn),
    .bus_req(bus_req), .bus_rdata(bus_rdata), .cmd(cmd), .busy(busy));
  sfct_flash_model sfct_flash_model_i (.sys_clk(sys_clk), .cmd(cmd));
  task automatic op(input logic rd, input sfct_addr_t a, input sfct_word_t v);
    @(posedge sys_clk);
    bus_req <= '{rd: rd, wr: !rd, addr: a, wdata: v};
    @(posedge sys_clk);
    bus_req <= '0;
    #1 d = bus_rdata;
  endtask
  task automatic settle;
    int n;
    n = 0;
    do begin
      @(posedge sys_clk);
      #1 n++;
    end while (busy !== 1'b0 && n < 400);
    if (n >= 400) `CHK(n, 0)
    @(posedge sys_clk);
    #1;
  endtask
  task automatic conclude;
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  // {op, 06h unlock, 50h unlock, gran, sector} of one region
  function automatic logic [12:0] region(sfct_word_t c, logic up);
    return up ? {c[15:8], c[4:0]} : {c[31:24], c[20:16]};
  endfunction
  // sector size in bytes for a two-bit size code
  function automatic logic [16:0] sect_size(logic [1:0] c);
    case (c)
      2'h0: return 17'h00100;
      2'h1: return 17'h01000;
      2'h2: return 17'h02000;
      default: return 17'h10000;
    endcase
  endfunction
  initial begin
    #200000 fails++;
    conclude();
  end
  initial begin
    repeat (8) @(posedge sys_clk);
    resetn <= 1'b1;
    repeat (3) @(posedge sys_clk);
    op(1, OFS_UPPER_MAP, 0);
    `CHK(d, 32'h0000ffff)
    op(0, OFS_STATUS, 32'hffffffff);
    op(1, OFS_STATUS, 0);
    `CHK(d, 32'h0)
    op(1, 13'h1020, 0);
    `CHK(d, 32'h0)
    b = 8'h10 | 8'($random(seed) & 7);
    // nine dwords: four whole entries, fifth lies outside
    op(0, OFS_UPPER_MAP, {16'h0, 8'h09, b});
    for (int i = 0; i < 5; i++) begin
      id[i] = $random(seed);
      id[i][7:0] = 8'(i);
      cap[i] = $random(seed) | 32'h80008000;
      cap[i][20:16] = {i % 3 == 1, i % 3 == 2, i[0], 2'(i)};
      cap[i][4:3] = {(i + 1) % 3 == 1, (i + 1) % 3 == 2};
      cap[i][2:0] = {i[1], 2'(3 - i)};
      op(0, {1'b0, b, 4'h0} + 13'(8 * i), id[i]);
      op(0, {1'b0, b, 4'h0} + 13'(8 * i + 4), cap[i]);
    end
    op(0, OFS_PART_ID, id[4]);
    op(0, OFS_CTRL, 32'h1);
    settle();
    op(0, OFS_CTRL, 32'h2);
    settle();
    op(1, OFS_STATUS, 0);
    `CHK(d, 32'hc)
    `CHK(sfct_flash_model_i.byte_log.size(), 0)
    for (int k = 0; k < 4; k++) begin
      op(0, OFS_PART_ID, {8'h0, id[k][23:0]});
      op(0, OFS_CTRL, 32'h1);
      settle();
      op(1, OFS_STATUS, 0);
      `CHK(d, {17'h0, 7'(k), 4'h0, k == 0, 3'h2})
      op(1, OFS_ACTIVE_CAP, 0);
      `CHK(d, cap[k])
      fba = ($random(seed) & 32'hffffff) | 32'h100;
      op(0, OFS_BOUNDARY, fba);
      for (int j = 0; j < 4; j++) begin
        r = region(cap[k], j[1]);
        op(0, OFS_FLASH_ADDR, j[1] ? fba + j[0] : fba - 1 - j[0]);
        op(1, OFS_DECODE, 0);
        `CHK(d, {18'h0, j[1], r})
        op(1, OFS_SIZES, 0);
        `CHK(d[30:24], r[2] ? 7'h40 : 7'h01)
        `CHK(d[16:0], sect_size(r[1:0]))
        exp_q = {};
        if (r[4] | r[3]) exp_q = {r[4] ? 8'h06 : 8'h50, OP_WRSR, 8'h00};
        exp_q.push_back(j[0] ? r[12:5] : OP_PROGRAM);
        sfct_flash_model_i.byte_log = {};
        op(0, OFS_CTRL, j[0] ? 32'h6 : 32'h2);
        settle();
        `CHK(sfct_flash_model_i.byte_log.size(), exp_q.size())
        foreach (exp_q[m])
          `CHK(sfct_flash_model_i.byte_log[m], exp_q[m])
      end
    end
    `CHK(sfct_flash_model_i.misuse, 0)
    conclude();
  end
endmodule
bind sfct_table sfct_props sfct_props_i (.sys_clk(sys_clk), .resetn(resetn),
  .bus_req(bus_req), .bus_rdata(bus_rdata), .cmd(cmd), .busy(busy));
